// file: pkg/ccf_pkg.sv
// constants for the control channel forwarding register bank
package ccf_pkg;
	// ==========================================
	// register offsets
	localparam logic [7:0] OFS_BIST = 8'h57;
	localparam logic [7:0] OFS_RLC = 8'h58;
	localparam logic [7:0] OFS_CTL1 = 8'h59;
	localparam logic [7:0] OFS_CTL2 = 8'h5A;
	localparam logic [7:0] OFS_SID = 8'h5B;
	localparam logic [7:0] OFS_ALIAS = 8'h5C;
	localparam logic [7:0] OFS_TID0 = 8'h5D;
	// ==========================================
	// back channel config fields
	localparam int RLC_FWD_ALL = 7;
	localparam int RLC_FWD_MATCH = 6;
	localparam int RLC_ACK_ALL = 5;
	localparam int RLC_PERM = 4;
	localparam int RLC_CSUM = 3;
	localparam int RLC_RATE_HI = 2;
	// ==========================================
	// path control and identity fields
	localparam int CTL1_KEEP = 7;
	localparam int CTL1_PINS_HI = 1;
	localparam int SID_LOCK = 0;
	localparam int ALIAS_AUTOACK = 0;
	// ==========================================
	// reset values and the tally limit
	localparam logic [7:0] RST_RLC = 8'h1E;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] BIST_MAX = 8'hFF;
	// ==========================================
	// rate codes and the alias-off value
	localparam logic [2:0] RATE_2M5 = 3'h0;
	localparam logic [2:0] RATE_10M = 3'h2;
	localparam logic [2:0] RATE_25M = 3'h5;
	localparam logic [2:0] RATE_50M = 3'h6;
	localparam logic [2:0] RATE_100M = 3'h7;
	localparam logic [6:0] ALIAS_OFF = 7'h00;
endpackage : ccf_pkg

// file: rtl/ccf_regs.sv
// control channel and i2c forwarding register bank
`timescale 1ns/1ps
module ccf_regs (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// register write and read port
	input wire logic wr_i,
	input wire logic wr_remote_i,
	input wire logic [7:0] wr_addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] rd_addr_i,
	output logic [7:0] rd_data_o,
	// forward channel loads and self-test
	input wire logic fc_load_i,
	input wire logic [6:0] fc_identity_i,
	input wire logic [1:0] fc_pin_count_i,
	input wire logic bist_err_i,
	// pins
	input wire logic power_down_pin_i,
	input wire logic [2:0] strap_rate_i,
	// incoming i2c transaction
	input wire logic txn_valid_i,
	input wire logic [7:0] txn_addr_i,
	input wire logic [7:0] txn_data_i,
	input wire logic [6:0] target_alias_0_i,
	// forwarded transaction
	output logic fwd_valid_o,
	output logic [7:0] fwd_addr_o,
	output logic [7:0] fwd_data_o,
	output logic auto_ack_o,
	// back channel controls
	output logic return_link_en_o,
	output logic return_link_checksum_gen_en_o,
	output logic [2:0] return_link_rate_sel_o,
	output logic [1:0] downstream_pin_count_o
);
	// ==========================================
	// state
	typedef struct packed {
		logic pd_s1; // first sync stage, read only by second
		logic pd_s2;
		logic pd_s3;
		logic pd_lvl; // filtered pin level
		logic [7:0] bist;
		logic [7:0] rlc;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] sid;
		logic [7:0] alias_r;
		logic [7:0] tid0;
		logic [7:0] rd;
		logic fv;
		logic [7:0] fa;
		logic [7:0] fd;
		logic ack;
	} ccf_state_s;

	ccf_state_s st_reg;
	ccf_state_s st_next;

	// ==========================================
	// helpers
	// register read mux, used only by the read port
	function automatic logic [7:0] ccf_read(input ccf_state_s s, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			ccf_pkg::OFS_BIST: v = s.bist;
			ccf_pkg::OFS_RLC: v = s.rlc;
			ccf_pkg::OFS_CTL1: v = s.ctl1;
			ccf_pkg::OFS_CTL2: v = s.ctl2;
			ccf_pkg::OFS_SID: v = s.sid;
			ccf_pkg::OFS_ALIAS: v = s.alias_r;
			ccf_pkg::OFS_TID0: v = {s.tid0[7:1], 1'b0};
			default: v = 8'h00; // unmapped reads as zero
		endcase
		return v;
	endfunction : ccf_read

	// legal rate codes; reserved ones are refused on write
	function automatic logic ccf_rate_ok(input logic [2:0] r);
		return r == ccf_pkg::RATE_2M5 || r == ccf_pkg::RATE_10M || r == ccf_pkg::RATE_25M
			|| r == ccf_pkg::RATE_50M || r == ccf_pkg::RATE_100M;
	endfunction : ccf_rate_ok

	// ==========================================
	// decode of the incoming transaction
	logic ser_hit;
	logic tgt_hit;
	logic fwd_now;
	logic is_write;
	logic pd_rise;

	always_comb
	begin
		// zero alias never matches, so the decode is off
		ser_hit = st_reg.alias_r[7:1] != ccf_pkg::ALIAS_OFF
			&& txn_addr_i[7:1] == st_reg.alias_r[7:1];
		tgt_hit = target_alias_0_i != ccf_pkg::ALIAS_OFF
			&& txn_addr_i[7:1] == target_alias_0_i;
		fwd_now = txn_valid_i && (st_reg.rlc[ccf_pkg::RLC_FWD_ALL]
			|| (st_reg.rlc[ccf_pkg::RLC_FWD_MATCH] && (ser_hit || tgt_hit)));
		is_write = !txn_addr_i[0];
		// a rise counts once stages two and three agree high
		pd_rise = st_reg.pd_s2 && st_reg.pd_s3 && !st_reg.pd_lvl;
	end

	// ==========================================
	// next state
	always_comb
	begin
		st_next = st_reg;
		st_next.pd_s1 = power_down_pin_i;
		st_next.pd_s2 = st_reg.pd_s1;
		st_next.pd_s3 = st_reg.pd_s2;
		if (st_reg.pd_s2 == st_reg.pd_s3)
		begin
			st_next.pd_lvl = st_reg.pd_s3;
		end
		// strap sets the rate default on power-down release
		if (pd_rise)
		begin
			st_next.rlc[ccf_pkg::RLC_RATE_HI:0] = strap_rate_i;
		end
		// self-test tally saturates instead of wrapping
		if (bist_err_i && st_reg.bist != ccf_pkg::BIST_MAX)
		begin
			st_next.bist = st_reg.bist + 8'h01;
		end
		// forward channel loads, each gated by its own lock
		if (fc_load_i && !st_reg.ctl1[ccf_pkg::CTL1_KEEP])
		begin
			st_next.ctl1[ccf_pkg::CTL1_PINS_HI:0] = fc_pin_count_i;
		end
		if (fc_load_i && !st_reg.sid[ccf_pkg::SID_LOCK])
		begin
			st_next.sid[7:1] = fc_identity_i;
		end
		// register writes win over same-cycle remote loads, except a CTL1 pin count written with the keep bit clear
		if (wr_i)
		begin
			unique case (wr_addr_i)
				ccf_pkg::OFS_RLC:
				begin
					st_next.rlc[7:5] = wr_data_i[7:5];
					st_next.rlc[ccf_pkg::RLC_CSUM] = wr_data_i[ccf_pkg::RLC_CSUM];
					if (!wr_remote_i)
					begin
						st_next.rlc[ccf_pkg::RLC_PERM] = wr_data_i[ccf_pkg::RLC_PERM];
					end
					if (ccf_rate_ok(wr_data_i[ccf_pkg::RLC_RATE_HI:0]))
					begin
						st_next.rlc[ccf_pkg::RLC_RATE_HI:0] = wr_data_i[ccf_pkg::RLC_RATE_HI:0];
					end
				end
				ccf_pkg::OFS_CTL1:
				begin
					st_next.ctl1[7:2] = wr_data_i[7:2];
					// local count only sticks while the keep bit is set
					if (wr_data_i[ccf_pkg::CTL1_KEEP])
					begin
						st_next.ctl1[1:0] = wr_data_i[1:0];
					end
				end
				ccf_pkg::OFS_CTL2: st_next.ctl2 = wr_data_i;
				ccf_pkg::OFS_SID: st_next.sid = wr_data_i;
				ccf_pkg::OFS_ALIAS: st_next.alias_r = wr_data_i;
				ccf_pkg::OFS_TID0: st_next.tid0 = {wr_data_i[7:1], 1'b0};
				default: ; // read-only or unmapped: ignored
			endcase
		end
		st_next.rd = ccf_read(st_reg, rd_addr_i);
		// forwarded transaction: only address bits swap
		st_next.fv = fwd_now;
		st_next.fd = txn_data_i;
		if (ser_hit)
		begin
			st_next.fa = {st_reg.sid[7:1], txn_addr_i[0]};
		end
		else if (tgt_hit)
		begin
			st_next.fa = {st_reg.tid0[7:1], txn_addr_i[0]};
		end
		else
		begin
			st_next.fa = txn_addr_i;
		end
		st_next.ack = txn_valid_i && is_write && (st_reg.rlc[ccf_pkg::RLC_ACK_ALL]
			|| (st_reg.alias_r[ccf_pkg::ALIAS_AUTOACK] && ser_hit));
	end

	// ==========================================
	// state register
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st_reg <= '0;
			st_reg.rlc <= ccf_pkg::RST_RLC;
			st_reg.ctl1 <= ccf_pkg::RST_ZERO;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ==========================================
	// outputs
	assign rd_data_o = st_reg.rd;
	assign fwd_valid_o = st_reg.fv;
	assign fwd_addr_o = st_reg.fa;
	assign fwd_data_o = st_reg.fd;
	assign auto_ack_o = st_reg.ack;
	assign return_link_en_o = st_reg.rlc[ccf_pkg::RLC_PERM] || st_reg.rlc[ccf_pkg::RLC_FWD_ALL]
		|| st_reg.rlc[ccf_pkg::RLC_FWD_MATCH];
	assign return_link_checksum_gen_en_o = st_reg.rlc[ccf_pkg::RLC_CSUM];
	assign return_link_rate_sel_o = st_reg.rlc[ccf_pkg::RLC_RATE_HI:0];
	assign downstream_pin_count_o = st_reg.ctl1[1:0];

	// ==========================================
	// checks
	// tally steps by one per error until it saturates
	chk_bist_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		bist_err_i && st_reg.bist != ccf_pkg::BIST_MAX
		|=> st_reg.bist == $past(st_reg.bist) + 8'h01)
		else $error("self-test tally did not count");
	// nothing but an error moves the tally, writes included
	chk_tally_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!bist_err_i |=> $stable(st_reg.bist))
		else $error("self-test tally moved without an error");
	chk_fwd_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && st_reg.rlc[ccf_pkg::RLC_FWD_ALL] |=> fwd_valid_o)
		else $error("forward-all transaction not forwarded");
	chk_fwd_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && !st_reg.rlc[ccf_pkg::RLC_FWD_ALL] && !ser_hit && !tgt_hit
		|=> !fwd_valid_o)
		else $error("unmatched transaction forwarded");
	// with both forwarding bits clear nothing goes out, matched or not
	chk_fwd_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && !st_reg.rlc[ccf_pkg::RLC_FWD_ALL]
		&& !st_reg.rlc[ccf_pkg::RLC_FWD_MATCH] |=> !fwd_valid_o)
		else $error("transaction forwarded with forwarding off");
	chk_ack_all: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && !txn_addr_i[0] && st_reg.rlc[ccf_pkg::RLC_ACK_ALL] |=> auto_ack_o)
		else $error("write not auto acknowledged");
	chk_link_enable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		return_link_en_o == (st_reg.rlc[4] | st_reg.rlc[7] | st_reg.rlc[6]))
		else $error("return link enable wrong");
	chk_perm_remote: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && wr_remote_i && wr_addr_i == ccf_pkg::OFS_RLC |=> $stable(st_reg.rlc[4]))
		else $error("remote write changed permanent bit");
	// a write in the release cycle or the one after may replace the strap value
	chk_strap_rate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pd_rise && !(wr_i && wr_addr_i == ccf_pkg::OFS_RLC)
		##1 !(wr_i && wr_addr_i == ccf_pkg::OFS_RLC)
		|=> return_link_rate_sel_o == $past(strap_rate_i, 2))
		else $error("strap rate not taken");
	chk_rate_legal: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		wr_i && wr_addr_i == ccf_pkg::OFS_RLC && !ccf_rate_ok(wr_data_i[2:0]) && !pd_rise
		|=> $stable(return_link_rate_sel_o))
		else $error("reserved rate accepted");
	chk_pin_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_reg.ctl1[ccf_pkg::CTL1_KEEP] && !wr_i |=> $stable(downstream_pin_count_o))
		else $error("kept pin count reloaded");
	chk_id_lock: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		st_reg.sid[ccf_pkg::SID_LOCK] && !wr_i |=> $stable(st_reg.sid))
		else $error("locked identity reloaded");
	chk_remap_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && tgt_hit && !ser_hit
		|=> fwd_addr_o == {$past(st_reg.tid0[7:1]), $past(txn_addr_i[0])})
		else $error("target remap wrong");
	chk_fwd_payload: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i |=> fwd_data_o == $past(txn_data_i))
		else $error("forwarded payload changed");
	chk_ser_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && !txn_addr_i[0] && ser_hit && st_reg.alias_r[ccf_pkg::ALIAS_AUTOACK]
		|=> auto_ack_o)
		else $error("serializer write not acknowledged");
	cov_fwd_ser: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && ser_hit && st_reg.rlc[ccf_pkg::RLC_FWD_MATCH] ##1 fwd_valid_o);
	cov_fwd_tgt: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && tgt_hit && st_reg.rlc[ccf_pkg::RLC_FWD_MATCH] ##1 fwd_valid_o);
	cov_strap: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) pd_rise);
	cov_ack_all: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		txn_valid_i && st_reg.rlc[ccf_pkg::RLC_ACK_ALL] ##1 auto_ack_o);
endmodule : ccf_regs

// file: tb/ccf_ser_model.sv
// remote serializer model that drives forward channel loads
`timescale 1ns/1ps
module ccf_ser_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// load request from the bench
	input wire logic send_i,
	input wire logic [6:0] id_i,
	input wire logic [1:0] pins_i,
	// forward channel load lines
	output logic fc_load_o,
	output logic [6:0] fc_identity_o,
	output logic [1:0] fc_pin_count_o
);
	// ==========================================
	// load launch
	// between loads the data lines toggle, so a stale value is never seen
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fc_load_o <= 1'b0;
			fc_identity_o <= 7'h00;
			fc_pin_count_o <= 2'h0;
		end
		else
		begin
			fc_load_o <= send_i;
			fc_identity_o <= send_i ? id_i : ~fc_identity_o;
			fc_pin_count_o <= send_i ? pins_i : ~fc_pin_count_o;
		end
	end
endmodule : ccf_ser_model

// file: tb/tb_ccf_regs.sv
// self-checking bench for the forwarding register bank
`timescale 1ns/1ps
module tb_ccf_regs;
	logic ref_clk_i, rst_n_i, wr_i, wr_remote_i, bist_err_i, pd_pin, txn_valid_i, send;
	logic [7:0] wr_addr_i, wr_data_i, rd_addr_i, rd_data_o, txn_addr_i, txn_data_i;
	logic [7:0] fwd_addr_o, fwd_data_o;
	logic [6:0] fc_id, tgt_alias, send_id;
	logic [1:0] fc_pins, pins_o, send_pins;
	logic [2:0] strap, rate_o, er;
	logic fc_load, fwd_valid_o, auto_ack_o, link_en_o, csum_o;
	int errors, n_tests;
	int cyc = 0;
	// ==========================================
	// design and far side
	ccf_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
		.wr_remote_i(wr_remote_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
		.rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .fc_load_i(fc_load),
		.fc_identity_i(fc_id), .fc_pin_count_i(fc_pins), .bist_err_i(bist_err_i),
		.power_down_pin_i(pd_pin), .strap_rate_i(strap), .txn_valid_i(txn_valid_i),
		.txn_addr_i(txn_addr_i), .txn_data_i(txn_data_i), .target_alias_0_i(tgt_alias),
		.fwd_valid_o(fwd_valid_o), .fwd_addr_o(fwd_addr_o), .fwd_data_o(fwd_data_o),
		.auto_ack_o(auto_ack_o), .return_link_en_o(link_en_o),
		.return_link_checksum_gen_en_o(csum_o), .return_link_rate_sel_o(rate_o),
		.downstream_pin_count_o(pins_o));
	ccf_ser_model ser (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .send_i(send),
		.id_i(send_id), .pins_i(send_pins), .fc_load_o(fc_load),
		.fc_identity_o(fc_id), .fc_pin_count_o(fc_pins));
	// ==========================================
	// clock and hang guard
	initial
	begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// run takes well under 400 cycles
	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors = errors + 1;
			print_verdict();
		end
	end
	// ==========================================
	// access tasks, entered at a falling edge except print_verdict from the hang guard
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
		wr_i = 1'b1;
		wr_addr_i = a;
		wr_data_i = d;
		wr_remote_i = rem;
		@(negedge ref_clk_i);
		wr_i = 1'b0;
		@(negedge ref_clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rd_addr_i = a;
		@(negedge ref_clk_i);
		chk("rd_data_o", e, rd_data_o);
	endtask : rd
	// link enable, checksum, rate, pin count packed in one byte
	task automatic ctl(input logic [7:0] e);
		chk("controls", e, {1'b0, link_en_o, csum_o, rate_o, pins_o});
	endtask : ctl
	task automatic tx(input logic [7:0] a, input logic [7:0] ea, input logic fv, input logic ak);
		txn_valid_i = 1'b1;
		txn_addr_i = a;
		txn_data_i = 8'h5A ^ a;
		@(negedge ref_clk_i);
		txn_valid_i = 1'b0;
		chk("fwd_valid_o", {7'h00, fv}, {7'h00, fwd_valid_o});
		chk("fwd_addr_o", ea, fwd_addr_o);
		chk("fwd_data_o", 8'h5A ^ a, fwd_data_o);
		chk("auto_ack_o", {7'h00, ak}, {7'h00, auto_ack_o});
		@(negedge ref_clk_i);
	endtask : tx
	task automatic ld(input logic [6:0] i, input logic [1:0] p);
		send = 1'b1;
		send_id = i;
		send_pins = p;
		@(negedge ref_clk_i);
		send = 1'b0;
		repeat (3) @(negedge ref_clk_i);
	endtask : ld
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// ==========================================
	// main sequence
	initial
	begin
		{rst_n_i, wr_i, wr_remote_i, bist_err_i, txn_valid_i, send} = 6'h00;
		{wr_addr_i, wr_data_i, rd_addr_i, txn_addr_i, txn_data_i} = 40'h0;
		{tgt_alias, send_id, send_pins} = 16'h0000;
		pd_pin = 1'b1;
		strap = 3'h5;
		errors = 0;
		n_tests = 0;
		repeat (3) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		rd(ccf_pkg::OFS_RLC, 8'h1D);
		ctl(8'h74);
		for (int k = 0; k < 7; k++)
			if (k != 1) rd(ccf_pkg::OFS_BIST + 8'(k), 8'h00);
		wr(ccf_pkg::OFS_BIST, 8'hFF, 1'b0);
		bist_err_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		bist_err_i = 1'b0;
		rd(ccf_pkg::OFS_BIST, 8'h03);
		rd(8'h40, 8'h00);
		// remote host sets auto-ack, then moves the rate; permanent bit must hold
		wr(ccf_pkg::OFS_RLC, 8'h2D, 1'b1);
		wr(ccf_pkg::OFS_RLC, 8'h28, 1'b1);
		rd(ccf_pkg::OFS_RLC, 8'h38);
		ctl(8'h60);
		wr(ccf_pkg::OFS_RLC, 8'h00, 1'b0);
		ctl(8'h00);
		tx(8'h00, 8'h00, 1'b0, 1'b0);
		// power-down pulse in mid-run reloads the rate from the strap
		strap = 3'h6;
		pd_pin = 1'b0;
		repeat (6) @(negedge ref_clk_i);
		pd_pin = 1'b1;
		repeat (6) @(negedge ref_clk_i);
		rd(ccf_pkg::OFS_RLC, 8'h06);
		er = 3'h0;
		for (int k = 0; k < 8; k++)
		begin
			wr(ccf_pkg::OFS_RLC, 8'h48 | 8'(k), 1'b0);
			if (k inside {0, 2, 5, 6, 7}) er = 3'(k);
			rd(ccf_pkg::OFS_RLC, {5'h09, er});
		end
		// forward channel loads versus local overrides
		ld(7'h2A, 2'h2);
		rd(ccf_pkg::OFS_SID, 8'h54);
		rd(ccf_pkg::OFS_CTL1, 8'h02);
		wr(ccf_pkg::OFS_CTL1, 8'h03, 1'b0);
		rd(ccf_pkg::OFS_CTL1, 8'h02);
		wr(ccf_pkg::OFS_CTL1, 8'h83, 1'b0);
		ld(7'h11, 2'h1);
		rd(ccf_pkg::OFS_CTL1, 8'h83);
		rd(ccf_pkg::OFS_SID, 8'h22);
		ctl(8'h7F);
		wr(ccf_pkg::OFS_SID, 8'hA7, 1'b0);
		ld(7'h01, 2'h0);
		rd(ccf_pkg::OFS_SID, 8'hA7);
		// transactions with match forwarding only, then with forward-all and ack-all
		tx(8'h00, 8'h00, 1'b0, 1'b0);
		wr(ccf_pkg::OFS_ALIAS, 8'h61, 1'b0);
		wr(ccf_pkg::OFS_TID0, 8'h45, 1'b0);
		rd(ccf_pkg::OFS_TID0, 8'h44);
		tgt_alias = 7'h31;
		tx(8'h60, 8'hA6, 1'b1, 1'b1);
		tx(8'h61, 8'hA7, 1'b1, 1'b0);
		tx(8'h62, 8'h44, 1'b1, 1'b0);
		tx(8'h70, 8'h70, 1'b0, 1'b0);
		wr(ccf_pkg::OFS_RLC, 8'hA7, 1'b0);
		tx(8'h70, 8'h70, 1'b1, 1'b1);
		print_verdict();
	end
endmodule : tb_ccf_regs
